// [logic/sih_host.sv]
// Host controller for the shared serial interrupt line
// Function
// - Line is shared open drain, link clocks
// - Cycle: start, IRQ/Data frames, one stop
// - Host then holds low, total 4-8
// - Host drives high one clock, then releases
// - Continuous mode: only host starts, 4-8 low
// - Reset puts both ends in continuous mode
// - Frame is sample, recovery, turn-around clocks
// - Frame one sampled at 2, then every 3
// - Fixed frame map of interrupts and channels
// - Only host ends cycle, stop low 2-3
// - Stop width selects next cycle's start mode
`timescale 1ns/10ps
module sih_host
	import sih_pkg::*;
#(
	parameter int FRAMES = SIH_FRAMES_DEF,
	parameter int IDLE_GAP = SIH_IDLE_GAP_DEF
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic clk_link_i,
	input wire logic enable_i,
	input wire logic [3:0] start_clks_i,
	input wire logic quiet_next_i,
	input wire logic sirq_i,
	output logic sirq_o,
	output logic sirq_oe_n_o,
	output logic [15:0] irq_o,
	output logic system_mgmt_interrupt_n_o,
	output logic io_channel_check_n_o,
	output logic [3:0] pci_int_n_o,
	output logic [31:0] frames_o,
	output logic update_o,
	output logic quiet_mode_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] clamp_start(input logic [3:0] req);
		if (req < SIH_START_MIN) begin
			clamp_start = SIH_START_MIN;
		end else if (req > SIH_START_MAX) begin
			clamp_start = SIH_START_MAX;
		end else begin
			clamp_start = req;
		end
	endfunction : clamp_start

	// ----------------------------------------------------------------
	// Link domain reset: async assert, synchronous release
	// ----------------------------------------------------------------
	logic rst_link_meta_reg;
	logic rst_link_reg;

	always_ff @(posedge clk_link_i or posedge rst_i) begin
		if (rst_i) begin
			rst_link_meta_reg <= 1'b1;
			rst_link_reg <= 1'b1;
		end else begin
			rst_link_meta_reg <= 1'b0;
			rst_link_reg <= rst_link_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// Configuration into the link domain
	// ----------------------------------------------------------------
	// Quasi-static settings; enable and start width taken while idle, quiet bit as the frames end, so bit skew is harmless
	logic [SIH_SYNC_W-1:0] cfg_sys;
	logic [SIH_SYNC_W-1:0] cfg_meta_reg;
	logic [SIH_SYNC_W-1:0] cfg_sync_reg;
	logic en_link;
	logic [3:0] start_link;
	logic quiet_link;

	assign cfg_sys = {quiet_next_i, start_clks_i, enable_i};

	genvar gi;
	generate
		for (gi = 0; gi < SIH_SYNC_W; gi++) begin : g_cfg_sync
			always_ff @(posedge clk_link_i or posedge rst_link_reg) begin
				if (rst_link_reg) begin
					cfg_meta_reg[gi] <= 1'b0;
					cfg_sync_reg[gi] <= 1'b0;
				end else begin
					cfg_meta_reg[gi] <= cfg_sys[gi];
					cfg_sync_reg[gi] <= cfg_meta_reg[gi];
				end
			end
		end
	endgenerate

	assign en_link = cfg_sync_reg[0];
	assign start_link = cfg_sync_reg[4:1];
	assign quiet_link = cfg_sync_reg[5];

	// ----------------------------------------------------------------
	// Link state machine
	// ----------------------------------------------------------------
	sih_state_t state_reg;
	logic [3:0] cnt_reg;
	logic [3:0] start_len_reg;
	logic [3:0] stop_len_reg;
	logic [1:0] phase_reg;
	logic [5:0] frame_reg;
	logic cont_reg;
	logic [7:0] gap_reg;
	logic gap_done;
	logic [31:0] word_reg;
	logic publish_reg;
	logic [4:0] sample_idx;

	sih_xfer_if xif ();

	assign gap_done = gap_reg >= 8'(IDLE_GAP);
	assign sample_idx = 5'(frame_reg - 6'h1);

	always_ff @(posedge clk_link_i or posedge rst_link_reg) begin
		if (rst_link_reg) begin
			state_reg <= SIH_IDLE;
			cnt_reg <= 4'h0;
			start_len_reg <= SIH_START_MIN;
			stop_len_reg <= SIH_STOP_CONT;
			phase_reg <= SIH_PH_TURN;
			frame_reg <= 6'h0;
		end else begin
			unique case (state_reg)
				SIH_IDLE: begin
					start_len_reg <= clamp_start(start_link);
					if (!cont_reg && !sirq_i) begin
						// Peripheral pulled the first clock; host extends it
						state_reg <= SIH_START;
						cnt_reg <= SIH_CNT_AFTER_PERIPH;
					end else if (cont_reg && en_link && gap_done) begin
						// Low on the line here is ignored: no peripheral start
						state_reg <= SIH_START;
						cnt_reg <= SIH_CNT_FIRST;
					end
				end
				SIH_START: begin
					if (cnt_reg >= start_len_reg) begin
						state_reg <= SIH_START_HI;
					end else begin
						cnt_reg <= cnt_reg + 4'h1;
					end
				end
				SIH_START_HI: begin
					// High clock is clock 0; first sample lands at clock 2
					state_reg <= SIH_FRAMES;
					phase_reg <= SIH_PH_TURN;
					frame_reg <= 6'h0;
				end
				SIH_FRAMES: begin
					unique case (phase_reg)
						SIH_PH_TURN: begin
							if (frame_reg == 6'(FRAMES)) begin
								state_reg <= SIH_STOP;
								cnt_reg <= SIH_CNT_FIRST;
								stop_len_reg <= quiet_link ? SIH_STOP_QUIET
									: SIH_STOP_CONT;
							end else begin
								phase_reg <= SIH_PH_SAMPLE;
								frame_reg <= frame_reg + 6'h1;
							end
						end
						SIH_PH_SAMPLE: phase_reg <= SIH_PH_RECOVER;
						SIH_PH_RECOVER: phase_reg <= SIH_PH_TURN;
						default: phase_reg <= SIH_PH_TURN;
					endcase
				end
				SIH_STOP: begin
					if (cnt_reg >= stop_len_reg) begin
						state_reg <= SIH_STOP_HI;
					end else begin
						cnt_reg <= cnt_reg + 4'h1;
					end
				end
				SIH_STOP_HI: state_reg <= SIH_IDLE;
			endcase
		end
	end

	// Mode for the next cycle follows the stop width
	always_ff @(posedge clk_link_i or posedge rst_link_reg) begin
		if (rst_link_reg) begin
			cont_reg <= 1'b1;
		end else if (state_reg == SIH_STOP && cnt_reg >= stop_len_reg) begin
			cont_reg <= stop_len_reg == SIH_STOP_CONT;
		end
	end

	// Spacing between host-started cycles in continuous mode
	always_ff @(posedge clk_link_i or posedge rst_link_reg) begin
		if (rst_link_reg) begin
			gap_reg <= 8'h0;
		end else if (state_reg != SIH_IDLE) begin
			gap_reg <= 8'h0;
		end else if (!gap_done) begin
			gap_reg <= gap_reg + 8'h1;
		end
	end

	// Sampled frames: a low line in a sample phase means asserted
	always_ff @(posedge clk_link_i or posedge rst_link_reg) begin
		if (rst_link_reg) begin
			word_reg <= 32'h0;
		end else if (state_reg == SIH_START_HI) begin
			word_reg <= 32'h0;
		end else if (state_reg == SIH_FRAMES && phase_reg == SIH_PH_SAMPLE) begin
			word_reg[sample_idx] <= ~sirq_i;
		end
	end

	// One word handed over per finished cycle; held while the crossing
	// is busy, so a slow ack delays the word instead of dropping it
	always_ff @(posedge clk_link_i or posedge rst_link_reg) begin
		if (rst_link_reg) begin
			publish_reg <= 1'b0;
		end else if (state_reg == SIH_STOP_HI) begin
			publish_reg <= 1'b1;
		end else begin
			publish_reg <= publish_reg && xif.src_busy;
		end
	end

	// ----------------------------------------------------------------
	// Line drive: low enable means driving
	// ----------------------------------------------------------------
	// Host drives only in its own start and stop; frames are left to
	// the peripherals, whose recovery drive ends each low sample
	always_comb begin
		unique case (state_reg)
			SIH_START, SIH_STOP: begin
				sirq_oe_n_o = 1'b0;
				sirq_o = 1'b0;
			end
			SIH_START_HI, SIH_STOP_HI: begin
				sirq_oe_n_o = 1'b0;
				sirq_o = 1'b1;
			end
			default: begin
				sirq_oe_n_o = 1'b1;
				sirq_o = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Crossing to the system domain
	// ----------------------------------------------------------------
	assign xif.src_data = word_reg;
	assign xif.src_valid = publish_reg;

	sih_xfer u_xfer (
		.clk_src_i(clk_link_i),
		.rst_src_i(rst_link_reg),
		.clk_dst_i(clk_sys_i),
		.rst_dst_i(rst_i),
		.x(xif.xfer)
	);

	logic mode_meta_reg;
	logic mode_sync_reg;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			mode_meta_reg <= 1'b1;
			mode_sync_reg <= 1'b1;
		end else begin
			mode_meta_reg <= cont_reg;
			mode_sync_reg <= mode_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// System side outputs
	// ----------------------------------------------------------------
	logic [31:0] frames_reg;
	logic update_reg;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			frames_reg <= 32'h0;
			update_reg <= 1'b0;
		end else begin
			update_reg <= xif.dst_valid;
			if (xif.dst_valid) begin
				frames_reg <= xif.dst_data;
			end
		end
	end

	// Frame 3 carries the management line, so irq 2 never reports
	always_comb begin
		irq_o = frames_reg[SIH_IRQ_BITS-1:0];
		irq_o[SIH_SMI_BIT] = 1'b0;
	end

	assign system_mgmt_interrupt_n_o = ~frames_reg[SIH_SMI_BIT];
	assign io_channel_check_n_o = ~frames_reg[SIH_IOCHK_BIT];
	assign pci_int_n_o = ~frames_reg[SIH_PCI_LSB +: SIH_PCI_BITS];
	assign frames_o = frames_reg;
	assign update_o = update_reg;
	assign quiet_mode_o = ~mode_sync_reg;

endmodule : sih_host

// [logic/sih_pkg.sv]
// Constants and types for the serial interrupt host controller
package sih_pkg;

	// ----------------------------------------------------------------
	// Frame timing, in link clocks
	// ----------------------------------------------------------------
	localparam int SIH_FRAME_CLKS = 3;
	localparam int SIH_FIRST_SAMPLE_CLK = 2;
	localparam logic [3:0] SIH_START_MIN = 4'h4;
	localparam logic [3:0] SIH_START_MAX = 4'h8;
	localparam logic [3:0] SIH_STOP_QUIET = 4'h2;
	localparam logic [3:0] SIH_STOP_CONT = 4'h3;
	localparam logic [3:0] SIH_CNT_FIRST = 4'h1;
	localparam logic [3:0] SIH_CNT_AFTER_PERIPH = 4'h2;

	// ----------------------------------------------------------------
	// Frame map
	// ----------------------------------------------------------------
	localparam int SIH_MAX_FRAMES = 32;
	localparam int SIH_FRAMES_DEF = 21;
	localparam int SIH_IRQ_BITS = 16;
	localparam int SIH_SMI_BIT = 2;
	localparam int SIH_IOCHK_BIT = 16;
	localparam int SIH_PCI_LSB = 17;
	localparam int SIH_PCI_BITS = 4;
	localparam int SIH_IDLE_GAP_DEF = 4;
	localparam int SIH_SYNC_W = 6;

	// ----------------------------------------------------------------
	// Phases within an IRQ/Data frame
	// ----------------------------------------------------------------
	localparam logic [1:0] SIH_PH_SAMPLE = 2'h0;
	localparam logic [1:0] SIH_PH_RECOVER = 2'h1;
	localparam logic [1:0] SIH_PH_TURN = 2'h2;

	typedef enum logic [2:0] {
		SIH_IDLE,
		SIH_START,
		SIH_START_HI,
		SIH_FRAMES,
		SIH_STOP,
		SIH_STOP_HI
	} sih_state_t;

endpackage : sih_pkg

// [logic/sih_xfer.sv]
// Toggle handshake moving one word from the link domain to the system domain
`timescale 1ns/10ps
module sih_xfer
	import sih_pkg::*;
(
	input wire logic clk_src_i,
	input wire logic rst_src_i,
	input wire logic clk_dst_i,
	input wire logic rst_dst_i,
	sih_xfer_if.xfer x
);

	logic [31:0] hold_reg;
	logic req_reg;
	logic ack_meta_reg;
	logic ack_sync_reg;
	logic req_meta_reg;
	logic req_sync_reg;
	logic req_seen_reg;
	logic [31:0] data_reg;
	logic valid_reg;

	// ----------------------------------------------------------------
	// Source side
	// ----------------------------------------------------------------
	// Word held until the ack returns, so the far side reads it stable
	assign x.src_busy = req_reg != ack_sync_reg;

	always_ff @(posedge clk_src_i or posedge rst_src_i) begin
		if (rst_src_i) begin
			hold_reg <= 32'h0;
			req_reg <= 1'b0;
		end else if (x.src_valid && !x.src_busy) begin
			hold_reg <= x.src_data;
			req_reg <= ~req_reg;
		end
	end

	always_ff @(posedge clk_src_i or posedge rst_src_i) begin
		if (rst_src_i) begin
			ack_meta_reg <= 1'b0;
			ack_sync_reg <= 1'b0;
		end else begin
			ack_meta_reg <= req_seen_reg;
			ack_sync_reg <= ack_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// Destination side
	// ----------------------------------------------------------------
	always_ff @(posedge clk_dst_i or posedge rst_dst_i) begin
		if (rst_dst_i) begin
			req_meta_reg <= 1'b0;
			req_sync_reg <= 1'b0;
		end else begin
			req_meta_reg <= req_reg;
			req_sync_reg <= req_meta_reg;
		end
	end

	always_ff @(posedge clk_dst_i or posedge rst_dst_i) begin
		if (rst_dst_i) begin
			req_seen_reg <= 1'b0;
			data_reg <= 32'h0;
			valid_reg <= 1'b0;
		end else begin
			valid_reg <= 1'b0;
			if (req_sync_reg != req_seen_reg) begin
				req_seen_reg <= req_sync_reg;
				data_reg <= hold_reg;
				valid_reg <= 1'b1;
			end
		end
	end

	assign x.dst_data = data_reg;
	assign x.dst_valid = valid_reg;

endmodule : sih_xfer

// [logic/sih_xfer_if.sv]
// Carrier for a sampled frame word crossing from link to system clock
`timescale 1ns/10ps
interface sih_xfer_if;
	logic [31:0] src_data;
	logic src_valid;
	logic src_busy;
	logic [31:0] dst_data;
	logic dst_valid;

	modport src (output src_data, output src_valid, input src_busy);
	modport xfer (input src_data, input src_valid, output src_busy,
		output dst_data, output dst_valid);
	modport dst (input dst_data, input dst_valid);
endinterface : sih_xfer_if

// [tb/sih_host_assertions.sv]
// Concurrent checks on the serial interrupt host ports
`timescale 1ns/10ps
module sih_host_assertions
	import sih_pkg::*;
#(
	parameter int FRAMES = SIH_FRAMES_DEF
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic clk_link_i,
	input wire logic [3:0] start_clks_i,
	input wire logic quiet_next_i,
	input wire logic sirq_i,
	input wire logic sirq_o,
	input wire logic sirq_oe_n_o,
	input wire logic [15:0] irq_o,
	input wire logic system_mgmt_interrupt_n_o,
	input wire logic io_channel_check_n_o,
	input wire logic [3:0] pci_int_n_o,
	input wire logic [31:0] frames_o,
	input wire logic update_o
);
	// ----------------
	// Line run counters
	// ----------------
	logic host_low;
	logic run_end;
	logic [3:0] clamp;
	logic [3:0] host_run_reg;
	logic [3:0] line_run_reg;
	logic [7:0] rel_cnt_reg;
	logic in_cycle_reg;
	assign host_low = !sirq_oe_n_o && !sirq_o;
	assign run_end = host_run_reg != 4'h0 && !host_low;
	assign clamp = (start_clks_i < 4'h4) ? 4'h4 : (start_clks_i > 4'h8) ? 4'h8 : start_clks_i;
	always_ff @(posedge clk_link_i or posedge rst_i) begin
		if (rst_i) begin
			host_run_reg <= 4'h0;
			line_run_reg <= 4'h0;
			rel_cnt_reg <= 8'h0;
			in_cycle_reg <= 1'b0;
		end else begin
			host_run_reg <= host_low ? host_run_reg + 4'h1 : 4'h0;
			line_run_reg <= !sirq_i ? line_run_reg + 4'h1 : 4'h0;
			rel_cnt_reg <= sirq_oe_n_o ? rel_cnt_reg + 8'h1 : 8'h0;
			if (run_end) begin
				in_cycle_reg <= (line_run_reg >= 4'h4);
			end
		end
	end
	// ----------------
	// Properties
	// ----------------
	a_start_width: assert property (@(posedge clk_link_i) disable iff (rst_i)
		run_end && line_run_reg >= 4'h4 |-> line_run_reg == clamp) else $error("start width");
	a_stop_width: assert property (@(posedge clk_link_i) disable iff (rst_i)
		run_end && line_run_reg < 4'h4 |-> line_run_reg == (quiet_next_i ? 4'h2 : 4'h3))
		else $error("stop width");
	a_high_after_low: assert property (@(posedge clk_link_i) disable iff (rst_i)
		run_end |-> !sirq_oe_n_o && sirq_o) else $error("no high clock");
	a_release_after_high: assert property (@(posedge clk_link_i) disable iff (rst_i)
		!sirq_oe_n_o && sirq_o |=> sirq_oe_n_o) else $error("high held too long");
	a_stop_position: assert property (@(posedge clk_link_i) disable iff (rst_i)
		host_low && host_run_reg == 4'h0 && in_cycle_reg |-> rel_cnt_reg == 3 * FRAMES + 1)
		else $error("stop misplaced");
	a_update_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		update_o |=> !update_o) else $error("update too long");
	a_word_held: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$changed(frames_o) |-> update_o) else $error("word changed alone");
	a_irq_map: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		update_o |-> irq_o == {frames_o[15:3], 1'b0, frames_o[1:0]}
		&& system_mgmt_interrupt_n_o == !frames_o[2]) else $error("irq map");
	a_chan_map: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		update_o |-> io_channel_check_n_o == !frames_o[16] && pci_int_n_o == ~frames_o[20:17])
		else $error("channel map");
	a_spare_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		update_o |-> (frames_o >> FRAMES) == 32'h0) else $error("spare frames set");
endmodule : sih_host_assertions

bind sih_host sih_host_assertions #(.FRAMES(FRAMES)) sih_host_assertions_inst (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_link_i(clk_link_i),
	.start_clks_i(start_clks_i), .quiet_next_i(quiet_next_i), .sirq_i(sirq_i),
	.sirq_o(sirq_o), .sirq_oe_n_o(sirq_oe_n_o), .irq_o(irq_o),
	.system_mgmt_interrupt_n_o(system_mgmt_interrupt_n_o),
	.io_channel_check_n_o(io_channel_check_n_o), .pci_int_n_o(pci_int_n_o),
	.frames_o(frames_o), .update_o(update_o));

// [tb/sih_host_tb_top.sv]
// Self-checking bench for the serial interrupt host controller
`timescale 1ns/10ps
module sih_host_tb_top;
	localparam int FR = 21;
	logic clk_sys_i, clk_link_i, rst_i, enable_i, quiet_next_i, rogue, line;
	logic h_o, h_oe_n, p_o, p_oe_n, update_o, quiet_mode_o, smi_n, chk_n;
	logic [3:0] start_clks_i, pci_n;
	logic [15:0] irq_o;
	logic [31:0] frames_o, irq_lvl;
	int mismatches, num_checks;
	logic [31:0] exp_q[$];
	// Pulled-up open drain wire
	assign line = ((!h_oe_n && !h_o) || (!p_oe_n && !p_o)) ? 1'b0 : 1'b1;
	sih_host #(.FRAMES(FR), .IDLE_GAP(4)) sih_host_inst (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_link_i(clk_link_i), .enable_i(enable_i),
		.start_clks_i(start_clks_i), .quiet_next_i(quiet_next_i), .sirq_i(line),
		.sirq_o(h_o), .sirq_oe_n_o(h_oe_n), .irq_o(irq_o), .system_mgmt_interrupt_n_o(smi_n),
		.io_channel_check_n_o(chk_n), .pci_int_n_o(pci_n), .frames_o(frames_o),
		.update_o(update_o), .quiet_mode_o(quiet_mode_o));
	sih_periph_model #(.FRAMES(FR)) sih_periph_model_inst (
		.clk_link_i(clk_link_i), .rst_i(rst_i), .line_i(line), .irq_i(irq_lvl),
		.rogue_start_i(rogue), .line_o(p_o), .line_oe_n_o(p_oe_n));
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		clk_link_i = 1'b0;
		#1.7;
		forever #3 clk_link_i = ~clk_link_i;
	end
	// ----------------
	// Tasks
	// ----------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wait_upd(output bit seen);
		seen = 1'b0;
		for (int i = 0; i < 400 && !seen; i++) begin
			@(negedge clk_sys_i);
			seen = (update_o === 1'b1);
		end
	endtask : wait_upd
	task automatic set_irq(input logic [31:0] v);
		@(negedge clk_sys_i);
		irq_lvl = v & ((32'h1 << FR) - 32'h1);
		exp_q.push_back(irq_lvl);
	endtask : set_irq
	task automatic expect_word;
		bit seen;
		logic [31:0] e;
		e = exp_q.pop_front();
		wait_upd(seen);
		check({31'h0, seen}, 32'h1);
		check(frames_o, e);
		check({16'h0, irq_o}, {16'h0, e[15:3], 1'b0, e[1:0]});
		check({26'h0, smi_n, chk_n, pci_n}, {26'h0, ~e[2], ~e[16], ~e[20:17]});
	endtask : expect_word
	task automatic expect_none;
		bit seen;
		wait_upd(seen);
		check({31'h0, seen}, 32'h0);
	endtask : expect_none
	task automatic go_idle;
		@(negedge clk_sys_i);
		enable_i = 1'b0;
		repeat (150) @(negedge clk_sys_i);
	endtask : go_idle
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		mismatches++;
		report_and_stop();
	end
	// ----------------
	// Tests
	// ----------------
	initial begin
		{rst_i, enable_i, quiet_next_i, rogue, start_clks_i, irq_lvl} = {1'b1, 7'h4, 32'h0};
		mismatches = 0;
		num_checks = 0;
		void'($urandom(32'h7483edeb));
		repeat (12) @(negedge clk_sys_i);
		check({23'h0, update_o, quiet_mode_o, smi_n, chk_n, pci_n, h_oe_n}, 32'h7f);
		check(frames_o | {16'h0, irq_o}, 32'h0);
		$display("test reset values done");
		rst_i = 1'b0;
		// Widths below 4 and above 8 are clamped
		for (int i = 0; i < 7; i++) begin
			go_idle();
			start_clks_i = 4'(i + 3);
			set_irq(i == 0 ? 32'hffffffff : (i == 1 ? 32'h0 : $urandom()));
			enable_i = 1'b1;
			expect_word();
			$display("test start width %0d done", i + 3);
		end
		go_idle();
		rogue = 1'b1;
		expect_none();
		rogue = 1'b0;
		$display("test refused start done");
		go_idle();
		quiet_next_i = 1'b1;
		start_clks_i = 4'($urandom_range(4, 8));
		set_irq($urandom());
		enable_i = 1'b1;
		expect_word();
		repeat (4) @(negedge clk_sys_i);
		check({31'h0, quiet_mode_o}, 32'h1);
		expect_none();
		set_irq(irq_lvl ^ 32'h5);
		expect_word();
		quiet_next_i = 1'b0;
		set_irq(irq_lvl ^ 32'h100000);
		expect_word();
		repeat (4) @(negedge clk_sys_i);
		check({31'h0, quiet_mode_o}, 32'h0);
		$display("test quiet mode done");
		report_and_stop();
	end
endmodule : sih_host_tb_top

// [tb/sih_periph_model.sv]
// Behavioural peripheral agent on the shared serial interrupt line
`timescale 1ns/10ps
module sih_periph_model #(
	parameter int FRAMES = 21
) (
	input wire logic clk_link_i,
	input wire logic rst_i,
	input wire logic line_i,
	input wire logic [31:0] irq_i,
	input wire logic rogue_start_i,
	output logic line_o,
	output logic line_oe_n_o
);
	// ----------------
	// Cycle tracking
	// ----------------
	int low_run, high_run, clk_cnt, fr;
	logic active, quiet, pstart;
	logic [31:0] held;
	always @(posedge clk_link_i or posedge rst_i) begin
		if (rst_i) begin
			low_run <= 0;
			high_run <= 0;
			clk_cnt <= 0;
			active <= 1'b0;
			quiet <= 1'b0;
			pstart <= 1'b0;
			held <= 32'h0;
		end else begin
			low_run <= line_i ? 0 : low_run + 1;
			high_run <= line_i ? high_run + 1 : 0;
			clk_cnt <= clk_cnt + 1;
			// Rogue start exists only to provoke the host's refusal
			pstart <= !pstart && !active && high_run >= 2 &&
				((quiet && irq_i != held) || rogue_start_i);
			if (line_i && low_run >= 4) begin
				active <= 1'b1;
				clk_cnt <= 1;
				held <= irq_i;
			end else if (line_i && (low_run == 2 || low_run == 3)) begin
				active <= 1'b0;
				quiet <= (low_run == 2);
			end
		end
	end
	always_comb begin
		fr = (clk_cnt + 1) / 3;
		line_oe_n_o = 1'b1;
		line_o = 1'b0;
		if (pstart) begin
			line_oe_n_o = 1'b0;
		end else if (active && fr >= 1 && fr <= FRAMES && held[fr - 1]) begin
			line_oe_n_o = (clk_cnt % 3 == 1);
			line_o = (clk_cnt % 3 == 0);
		end
	end
endmodule : sih_periph_model
